// ### pkg/nsc_params.svh
`ifndef NSC_PARAMS_SVH
`define NSC_PARAMS_SVH

`define NSC_CLK_MHZ 40
`define NSC_PWR_US 100
`define NSC_PWR_CYC ((`NSC_PWR_US) * (`NSC_CLK_MHZ))
`define NSC_WHR_NS 60
`define NSC_WHR_CYC (((`NSC_WHR_NS) * (`NSC_CLK_MHZ) + 999) / 1000)
`define NSC_WB_NS 100
`define NSC_WB_CYC (((`NSC_WB_NS) * (`NSC_CLK_MHZ) + 999) / 1000)
`define NSC_DIV_DEF 2

`define NSC_CMD_STAT 8'h70
`define NSC_CMD_PLANE 8'hF1
`define NSC_CMD_ID 8'h90
`define NSC_CMD_RST 8'hFF
`define NSC_CMD_READ 8'h00
`define NSC_ID_ADDR 8'h00
`define NSC_ID_LAST 3'h4

`define NSC_OFF_CTRL 12'h000
`define NSC_OFF_STATE 12'h004
`define NSC_OFF_STAT 12'h008
`define NSC_OFF_ID0 12'h00C
`define NSC_OFF_ID1 12'h010

`define NSC_CTRL_LOCK 8
`define NSC_SB_READY 6
`define NSC_MASK_STAT 8'hC1
`define NSC_MASK_PLANE 8'hC7
`define NSC_STAT_RESET 8'hC0
`define NSC_STAT_RESET_WP 8'h40

`endif

// ### pkg/nsc_pkg.sv
package nsc_pkg;

  typedef enum logic [3:0] {
    S_PWR = 4'h0,
    S_IDLE = 4'h1,
    S_WE_LO = 4'h2,
    S_WE_HI = 4'h3,
    S_GAP = 4'h4,
    S_POLL = 4'h5,
    S_RD_LO = 4'h6,
    S_RD_HI = 4'h7,
    S_BUSY_LO = 4'h8,
    S_BUSY_HI = 4'h9
  } nsc_state_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_STAT = 3'h1,
    OP_PLANE = 3'h2,
    OP_ID = 3'h3,
    OP_RST = 3'h4,
    OP_READ = 3'h5
  } nsc_op_e;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic io_oe;
    logic [7:0] io_out;
  } nsc_pins_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } nsc_apb_req_s;

endpackage

// ### verilog/nsc_tick.sv
`timescale 1ns/1ps
`default_nettype none
module nsc_tick #(
  parameter int DIV = 2
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic run, // counting enabled
  output logic tick // one-cycle enable pulse
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  always_comb begin
    if (!run || cnt_r == 8'(DIV - 1)) begin
      cnt_nxt = 8'h00;
    end else begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick = run && cnt_r == 8'(DIV - 1);
endmodule
`default_nettype wire

// ### verilog/nsc_ctrl.sv
// Operation
// - status mode persists; controller reissues 00h before resuming reads.
// - controller polls a single device through its one chip select, ce_n.
// - controller masks unused status bits before evaluating.
// - ID mode entered by 90h then one address cycle of 00h.
// - controller waits at least 100us after power-up before commands.
// - controller holds write-protect low through power-up.
// - controller never asserts write-protect while device is busy.
`timescale 1ns/1ps
`default_nettype none
`include "nsc_params.svh"
module nsc_ctrl
  import nsc_pkg::*;
#(
  parameter int DIV = `NSC_DIV_DEF,
  parameter int PWR_CYC = `NSC_PWR_CYC
) (
  input wire logic clk, // 40 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire nsc_apb_req_s apb, // apb request
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  output nsc_pins_s pins, // flash pin drive
  input wire logic [7:0] io_in, // flash io lines
  input wire logic ready_busy, // wired ready/busy line
  output logic program_lock_n // write-protect pin
);
  logic rst_m_r;
  logic rst_n;
  nsc_state_e st_r, st_nxt;
  nsc_op_e op_r, op_nxt;
  nsc_pins_s pin_r, pin_nxt;
  logic [11:0] wait_r, wait_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic addr_r, addr_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [39:0] id_r, id_nxt;
  logic stat_ok_r, stat_ok_nxt;
  logic id_ok_r, id_ok_nxt;
  logic lock_req_r, lock_req_nxt;
  logic lock_r, lock_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic tick;
  logic setup;
  logic wr;
  logic mapped;
  nsc_op_e go_op;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_m_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n <= rst_m_r;
    end
  end

  nsc_tick #(.DIV(DIV)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .run(st_r != S_IDLE && st_r != S_PWR),
    .tick(tick)
  );

  function automatic logic [7:0] cmd_of(input nsc_op_e op);
    unique case (op)
      OP_STAT: cmd_of = `NSC_CMD_STAT;
      OP_PLANE: cmd_of = `NSC_CMD_PLANE;
      OP_ID: cmd_of = `NSC_CMD_ID;
      OP_RST: cmd_of = `NSC_CMD_RST;
      default: cmd_of = `NSC_CMD_READ;
    endcase
  endfunction

  function automatic logic [7:0] mask_of(input nsc_op_e op,
                                         input logic [7:0] v);
    mask_of = v & ((op == OP_PLANE) ? `NSC_MASK_PLANE
                                    : `NSC_MASK_STAT);
  endfunction

  function automatic logic is_reg(input logic [11:0] a);
    is_reg = a == `NSC_OFF_CTRL || a == `NSC_OFF_STATE ||
             a == `NSC_OFF_STAT || a == `NSC_OFF_ID0 ||
             a == `NSC_OFF_ID1;
  endfunction

  assign setup = apb.psel && !apb.penable;
  assign wr = apb.psel && apb.penable && apb.pwrite;
  assign mapped = is_reg(apb.paddr);
  assign go_op = nsc_op_e'(apb.pwdata[2:0]);
  assign pready = 1'b1;
  assign pslverr = apb.psel && apb.penable && !is_reg(apb.paddr);
  assign prdata = rd_r;
  assign pins = pin_r;
  assign program_lock_n = !lock_r;

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    pin_nxt = pin_r;
    wait_nxt = wait_r;
    idx_nxt = idx_r;
    addr_nxt = addr_r;
    stat_nxt = stat_r;
    id_nxt = id_r;
    stat_ok_nxt = stat_ok_r;
    id_ok_nxt = id_ok_r;
    lock_req_nxt = lock_req_r;
    rd_nxt = rd_r;
    if (wr && apb.paddr == `NSC_OFF_CTRL) begin
      lock_req_nxt = apb.pwdata[`NSC_CTRL_LOCK];
    end
    // lock rises only with line ready and controller idle
    lock_nxt = lock_r;
    if (st_r == S_PWR) begin
      lock_nxt = 1'b1;
    end else if (!lock_req_r) begin
      lock_nxt = 1'b0;
    end else if (ready_busy && st_r == S_IDLE) begin
      lock_nxt = 1'b1;
    end
    unique case (st_r)
      S_PWR: begin
        wait_nxt = wait_r + 12'h001;
        if (wait_r == 12'(PWR_CYC - 1)) begin
          st_nxt = S_IDLE;
          wait_nxt = 12'h000;
        end
      end
      S_IDLE: begin
        if (wr && apb.paddr == `NSC_OFF_CTRL && go_op != OP_NONE &&
            go_op <= OP_READ) begin
          op_nxt = go_op;
          addr_nxt = 1'b0;
          pin_nxt.ce_n = 1'b0;
          pin_nxt.cle = 1'b1;
          pin_nxt.ale = 1'b0;
          pin_nxt.we_n = 1'b0;
          pin_nxt.io_oe = 1'b1;
          pin_nxt.io_out = cmd_of(go_op);
          if (go_op == OP_STAT || go_op == OP_PLANE) begin
            stat_ok_nxt = 1'b0;
          end
          if (go_op == OP_ID) begin
            id_ok_nxt = 1'b0;
          end
          st_nxt = S_WE_LO;
        end
      end
      S_WE_LO: begin
        if (tick) begin
          pin_nxt.we_n = 1'b1;
          st_nxt = S_WE_HI;
        end
      end
      S_WE_HI: begin
        if (tick) begin
          if (op_r == OP_ID && !addr_r) begin
            addr_nxt = 1'b1;
            pin_nxt.cle = 1'b0;
            pin_nxt.ale = 1'b1;
            pin_nxt.we_n = 1'b0;
            pin_nxt.io_out = `NSC_ID_ADDR;
            st_nxt = S_WE_LO;
          end else begin
            pin_nxt.cle = 1'b0;
            pin_nxt.ale = 1'b0;
            pin_nxt.io_oe = 1'b0;
            wait_nxt = 12'h000;
            idx_nxt = 3'h0;
            unique case (op_r)
              OP_RST: st_nxt = S_BUSY_LO;
              OP_READ: begin
                pin_nxt.ce_n = 1'b1;
                st_nxt = S_IDLE;
              end
              default: st_nxt = S_GAP;
            endcase
          end
        end
      end
      S_GAP: begin
        wait_nxt = wait_r + 12'h001;
        if (wait_r == 12'(`NSC_WHR_CYC - 1)) begin
          pin_nxt.read_strobe_n = 1'b0;
          st_nxt = (op_r == OP_ID) ? S_RD_LO : S_POLL;
        end
      end
      S_POLL: begin
        // strobe held low; device refreshes the byte itself
        if (tick) begin
          stat_nxt = io_in;
          if (io_in[`NSC_SB_READY]) begin
            stat_ok_nxt = 1'b1;
            pin_nxt.read_strobe_n = 1'b1;
            pin_nxt.ce_n = 1'b1;
            st_nxt = S_IDLE;
          end
        end
      end
      S_RD_LO: begin
        if (tick) begin
          id_nxt[8 * idx_r +: 8] = io_in;
          pin_nxt.read_strobe_n = 1'b1;
          st_nxt = S_RD_HI;
        end
      end
      S_RD_HI: begin
        if (tick) begin
          if (idx_r == `NSC_ID_LAST) begin
            id_ok_nxt = 1'b1;
            pin_nxt.ce_n = 1'b1;
            st_nxt = S_IDLE;
          end else begin
            idx_nxt = idx_r + 3'h1;
            pin_nxt.read_strobe_n = 1'b0;
            st_nxt = S_RD_LO;
          end
        end
      end
      S_BUSY_LO: begin
        wait_nxt = wait_r + 12'h001;
        if (wait_r == 12'(`NSC_WB_CYC - 1)) begin
          st_nxt = S_BUSY_HI;
        end
      end
      S_BUSY_HI: begin
        if (ready_busy) begin
          // fresh status after reset: ready, protect bit follows lock
          stat_nxt = lock_r ? `NSC_STAT_RESET_WP
                            : `NSC_STAT_RESET;
          stat_ok_nxt = 1'b0;
          pin_nxt.ce_n = 1'b1;
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    if (setup) begin
      unique case (apb.paddr)
        `NSC_OFF_CTRL: rd_nxt = {23'h0, lock_req_r, 5'h0, op_r};
        `NSC_OFF_STATE: rd_nxt = {26'h0, id_ok_r, stat_ok_r, lock_r,
                                  st_r != S_PWR, ready_busy,
                                  st_r != S_IDLE};
        `NSC_OFF_STAT: rd_nxt = {16'h0, stat_r, mask_of(op_r, stat_r)};
        `NSC_OFF_ID0: rd_nxt = id_r[31:0];
        `NSC_OFF_ID1: rd_nxt = {24'h0, id_r[39:32]};
        default: rd_nxt = 32'h0;
      endcase
      if (!mapped) begin
        rd_nxt = 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_PWR;
      op_r <= OP_NONE;
      pin_r <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                 read_strobe_n: 1'b1, io_oe: 1'b0, io_out: 8'h00};
      wait_r <= 12'h000;
      idx_r <= 3'h0;
      addr_r <= 1'b0;
      stat_r <= 8'h00;
      id_r <= 40'h0;
      stat_ok_r <= 1'b0;
      id_ok_r <= 1'b0;
      lock_req_r <= 1'b0;
      lock_r <= 1'b1;
      rd_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      pin_r <= pin_nxt;
      wait_r <= wait_nxt;
      idx_r <= idx_nxt;
      addr_r <= addr_nxt;
      stat_r <= stat_nxt;
      id_r <= id_nxt;
      stat_ok_r <= stat_ok_nxt;
      id_ok_r <= id_ok_nxt;
      lock_req_r <= lock_req_nxt;
      lock_r <= lock_nxt;
      rd_r <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// ### verif/nsc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module nsc_ctrl_asserts
  import nsc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire nsc_apb_req_s apb, // apb request
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire nsc_pins_s pins, // flash strobes
  input wire logic [7:0] io_in, // flash io
  input wire logic ready_busy, // ready line
  input wire logic program_lock_n // write-protect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic we_r, we_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic acc, stat;
  always_comb begin
    we_nxt = pins.we_n;
    cmd_nxt = (pins.we_n && !we_r && pins.cle) ? pins.io_out : cmd_r;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      we_r <= 1'b1;
      cmd_r <= 8'h00;
    end else begin
      we_r <= we_nxt;
      cmd_r <= cmd_nxt;
    end
  end
  assign acc = apb.psel && apb.penable;
  assign stat = cmd_r == 8'h70 || cmd_r == 8'hF1;
  sequence s_id_cmd;
    $rose(pins.we_n) && pins.cle && pins.io_out == 8'h90;
  endsequence
  sequence s_id_addr;
    $rose(pins.we_n) && pins.ale && pins.io_out == 8'h00;
  endsequence
  AST_PREADY: assert property (acc |-> pready)
    else $error("access not answered");
  AST_UNMAPPED: assert property (acc && apb.paddr > 12'h010
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  AST_PWR_LOCK: assert property ($rose(arst_n) |-> !program_lock_n [*8])
    else $error("lock released in power wait");
  AST_PWR_QUIET: assert property ($rose(arst_n) |-> pins.ce_n [*8])
    else $error("command during power wait");
  AST_LOCK_IDLE: assert property ($fell(program_lock_n) |-> $past(ready_busy))
    else $error("lock applied while busy");
  AST_ID_ADDR: assert property (s_id_cmd |-> ##[1:12] s_id_addr)
    else $error("id address cycle missing");
  AST_STAT_HOLD: assert property (stat && !pins.read_strobe_n && !io_in[6]
    |=> !pins.read_strobe_n && !pins.ce_n) else $error("poll ended early");
  AST_NO_CLASH: assert property (!pins.read_strobe_n |-> !pins.io_oe)
    else $error("io driven during read");
endmodule
bind nsc_ctrl nsc_ctrl_asserts u_asserts (
  .clk(clk), .arst_n(arst_n), .apb(apb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .io_in(io_in),
  .ready_busy(ready_busy), .program_lock_n(program_lock_n)
);
`default_nettype wire

// ### verif/nsc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module nsc_flash_model
  import nsc_pkg::*;
#(
  parameter int RST_NS = 500
) (
  input wire nsc_pins_s pins, // strobes
  input wire logic program_lock_n, // write-protect
  input wire logic busy_req, // hold array busy
  input wire logic [2:0] fail, // plane1, plane0, chip
  output logic [7:0] io, // io toward controller
  output logic rb_low // open-drain pull-down
);
  // arbitrary identification values
  localparam logic [39:0] ID = 40'h55443322A1;
  logic [7:0] cmd = 8'h00;
  logic id_on = 1'b0;
  logic rst_busy = 1'b0;
  logic [2:0] idx = 3'h0;
  logic [7:0] st, val;
  logic drv;
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle) begin
      cmd = pins.io_out;
      id_on = 1'b0;
      if (cmd == 8'hFF) begin
        rst_busy = 1'b1;
        #(RST_NS) rst_busy = 1'b0;
      end
    end else if (!pins.ce_n && pins.ale && cmd == 8'h90) begin
      id_on = pins.io_out == 8'h00;
      idx = 3'h0;
    end
  end
  always @(posedge pins.read_strobe_n) begin
    if (id_on && idx < 3'h4) begin
      idx = idx + 3'h1;
    end
  end
  assign rb_low = busy_req || rst_busy;
  assign st = {program_lock_n, !rb_low, 3'h5,
    cmd == 8'hF1 ? fail[2:1] : 2'h2, fail[0]};
  assign val = id_on ? ID[8*idx +: 8] : st;
  assign drv = !pins.ce_n && !pins.read_strobe_n
    && (id_on || cmd == 8'h70 || cmd == 8'hF1);
  assign io = drv ? val : ~val;
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import nsc_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, busy_req = 1'b0;
  logic pready, pslverr, program_lock_n, rb_low, ready_busy;
  logic [2:0] fail = 3'h0;
  logic [7:0] mio, io_in;
  logic [31:0] prdata;
  nsc_apb_req_s apb = '0;
  nsc_pins_s pins;
  int num_errors = 0, n_compared = 0;
  assign io_in = pins.io_oe ? pins.io_out : mio;
  assign ready_busy = !rb_low;
  nsc_ctrl #(.PWR_CYC(20)) dut (.clk(clk), .arst_n(arst_n), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .io_in(io_in), .ready_busy(ready_busy), .program_lock_n(program_lock_n));
  nsc_flash_model flash (.pins(pins), .program_lock_n(program_lock_n),
    .busy_req(busy_req), .fail(fail), .io(mio), .rb_low(rb_low));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic idle;
    logic [31:0] q;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    do begin
      rd(12'h004, q);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    chk(32'(q[0]), 32'h0);
  endtask
  task automatic t_power;
    logic [31:0] q;
    wr(12'h000, 32'h1);
    rd(12'h004, q);
    chk(32'({q[2], q[0]}), 32'h1);
    chk(32'(program_lock_n), 32'h0);
    repeat (30) @(posedge clk);
    rd(12'h004, q);
    chk(32'({q[2], q[0]}), 32'h2);
  endtask
  task automatic t_reset;
    logic [31:0] q;
    for (int i = 0; i < 2; i++) begin
      wr(12'h000, 32'h4);
      repeat (8) @(posedge clk);
      rd(12'h004, q);
      chk(32'(q[1]), 32'h0);
      idle();
      rd(12'h008, q);
      chk(32'(q[7:0]), 32'hC0);
    end
  endtask
  task automatic t_status;
    logic [31:0] q;
    logic [7:0] r;
    for (int op = 1; op <= 2; op++) begin
      fail <= op == 1 ? 3'h1 : 3'h6;
      busy_req <= 1'b1;
      wr(12'h000, 32'(op));
      repeat (30) @(posedge clk);
      rd(12'h004, q);
      chk(32'(q[0]), 32'h1);
      busy_req <= 1'b0;
      idle();
      rd(12'h004, q);
      chk(32'(q[4]), 32'h1);
      r = {5'h1D, op == 1 ? 2'h2 : fail[2:1], fail[0]};
      rd(12'h008, q);
      chk(32'(q[15:0]), 32'({r, r & (op == 1 ? 8'hC1 : 8'hC7)}));
    end
    wr(12'h000, 32'h100);
    repeat (4) @(posedge clk);
    wr(12'h000, 32'h101);
    idle();
    rd(12'h008, q);
    chk(32'(q[7:0]), 32'h40);
    wr(12'h000, 32'h104);
    idle();
    rd(12'h008, q);
    chk(32'(q[7:0]), 32'h40);
    wr(12'h000, 32'h0);
  endtask
  task automatic t_id;
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 2; i++) begin
      wr(12'h000, 32'h3);
      idle();
      rd(12'h004, q);
      chk(32'(q[5]), 32'h1);
      rd(12'h00C, q);
      chk(q, 32'h443322A1);
      rd(12'h010, q);
      chk(32'(q[7:0]), 32'h55);
      wr(12'h000, 32'h5);
      idle();
    end
    xfer(1'b0, 12'h014, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h80000000);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_power();
    t_reset();
    t_status();
    t_id();
    end_sim();
  end
  initial begin
    #2000000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
